// ==== core/bldl_pkg.sv ====
// Purpose: Constants for the byte lane delay and latency register bank
// Assumes: 32-bit Avalon-MM slave, byte addresses in a 16-byte window
// Notes: Offsets are word aligned; reserved bits read as zero
package bldl_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_GATE = 4'h0;
    localparam logic [3:0] OFS_MDP = 4'h4;
    localparam logic [3:0] OFS_LAT = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hC;
    // Field widths and positions
    localparam int RANKS = 4;
    localparam int GD_W = 8;
    localparam int WLSL_W = 2;
    localparam int DGSL_W = 3;
    localparam int MASTER_LINE_DELAY_LSB = 16;
    localparam int TARGET_PERIOD_LSB = 8;
    localparam int INITIAL_PERIOD_LSB = 0;
    localparam int WLSL_LSB = 12;
    localparam int DGSL_LSB = 0;
    localparam int CTRL_DRIFT = 0;
    localparam int CTRL_MDLUPD = 1;
    localparam int CTRL_CALED = 2;
    // Writable masks, reserved bits stay zero
    localparam logic [31:0] MDP_MASK = 32'h00FF_FFFF;
    localparam logic [31:0] LAT_MASK = 32'h000F_FFFF;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
    // Reset values
    localparam logic [31:0] GATE_RST = 32'h0000_0000;
    localparam logic [31:0] MDP_RST = 32'h0000_0000;
    localparam logic [31:0] LAT_RST = 32'h0005_5000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;
    // Bus answer states
    typedef enum logic [0:0] {BLDL_IDLE, BLDL_ACK} bldl_bus_t;
endpackage

// ==== core/bldl_regs.sv ====
// Purpose: Per-lane gate delay, master delay period and system latency registers
// Assumes: Training and calibration logic runs on clk and drives one-cycle strobes
// Notes: Software writes win over hardware loads in the same cycle
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps

module bldl_regs
    import bldl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Calibration and training strobes
    input wire logic cal_done,
    input wire logic [7:0] cal_period,
    input wire logic period_valid,
    input wire logic [7:0] period_meas,
    input wire logic wl_load,
    input wire logic [7:0] wl_lat_in,
    input wire logic dg_load,
    input wire logic [11:0] dg_lat_in,
    // Settings towards the lane
    output logic [31:0] gate_delay_o,
    output logic [7:0] mdl_delay_o,
    output logic [7:0] wl_sys_lat_o,
    output logic [11:0] dg_sys_lat_o,
    output logic drift_comp_en_o
);

    // Bus state, read data and register images
    bldl_bus_t bus_r, bus_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] gate_r, gate_nxt;
    logic [31:0] mdp_r, mdp_nxt;
    logic [31:0] lat_r, lat_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic caled_r, caled_nxt;
    logic wr_go, rd_go;

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // One wait state per access keeps read data registered
    // A request still held after its answer starts a fresh access
    assign wr_go = avs_write && (bus_r == BLDL_IDLE);
    assign rd_go = avs_read && (bus_r == BLDL_IDLE);
    assign avs_waitrequest = (avs_read || avs_write) && (bus_r != BLDL_ACK);
    assign avs_readdata = rdata_r;

    // Bus sequencing and read mux
    always_comb begin
        bus_nxt = BLDL_IDLE;
        rdata_nxt = rdata_r;
        if (rd_go || wr_go) begin
            bus_nxt = BLDL_ACK;
        end
        if (rd_go) begin
            case (avs_address)
                OFS_GATE: rdata_nxt = gate_r;
                OFS_MDP: rdata_nxt = mdp_r & MDP_MASK;
                OFS_LAT: rdata_nxt = lat_r & LAT_MASK;
                // Status bit is read-only; the write mask keeps it out of ctrl_r
                OFS_CTRL: rdata_nxt = {29'h0, caled_r, ctrl_r[1:0]};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_r <= BLDL_IDLE;
            rdata_r <= 32'h0000_0000;
        end else begin
            bus_r <= bus_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Field updates: calibration, measurement, training, then software
    // Software is applied last so that it overrides a same-cycle load
    always_comb begin
        int old_half;
        int new_half;
        int adj;
        old_half = 0;
        new_half = 0;
        adj = 0;
        gate_nxt = gate_r;
        mdp_nxt = mdp_r;
        lat_nxt = lat_r;
        ctrl_nxt = ctrl_r;
        caled_nxt = caled_r;
        if (cal_done) begin
            mdp_nxt[INITIAL_PERIOD_LSB +: 8] = cal_period;
            mdp_nxt[TARGET_PERIOD_LSB +: 8] = cal_period;
            mdp_nxt[MASTER_LINE_DELAY_LSB +: 8] = cal_period;
            for (int r = 0; r < RANKS; r++) begin
                gate_nxt[r*GD_W +: GD_W] = {1'b0, cal_period[7:1]};
            end
            caled_nxt = 1'b1;
        end else if (period_valid && ctrl_r[CTRL_MDLUPD]) begin
            mdp_nxt[TARGET_PERIOD_LSB +: 8] = period_meas;
            mdp_nxt[MASTER_LINE_DELAY_LSB +: 8] = period_meas;
            if (ctrl_r[CTRL_DRIFT] && caled_r) begin
                // Shift by the change in half period, clamped to the line range
                // Clamping, not wrapping, stops a large drift jumping the gate
                old_half = int'(mdp_r[TARGET_PERIOD_LSB+1 +: 7]);
                new_half = int'(period_meas[7:1]);
                for (int r = 0; r < RANKS; r++) begin
                    adj = int'(gate_r[r*GD_W +: GD_W]) + new_half - old_half;
                    if (adj < 0) begin
                        adj = 0;
                    end else if (adj > 255) begin
                        adj = 255;
                    end
                    gate_nxt[r*GD_W +: GD_W] = adj[7:0];
                end
            end
        end
        if (wl_load) begin
            lat_nxt[WLSL_LSB +: 8] = wl_lat_in;
        end
        if (dg_load) begin
            lat_nxt[DGSL_LSB +: 12] = dg_lat_in;
        end
        // Code 11 is stored as written; the far side never programs it
        if (wr_go) begin
            case (avs_address)
                OFS_GATE: gate_nxt = merge(gate_r, avs_writedata, avs_byteenable);
                OFS_MDP: mdp_nxt = merge(mdp_r, avs_writedata, avs_byteenable) & MDP_MASK;
                OFS_LAT: lat_nxt = merge(lat_r, avs_writedata, avs_byteenable) & LAT_MASK;
                OFS_CTRL: ctrl_nxt = merge(ctrl_r, avs_writedata, avs_byteenable) & CTRL_MASK;
                default: ;
            endcase
        end
    end

    // Reset leaves write latency at 01 and gate latency at 000
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_r <= GATE_RST;
            mdp_r <= MDP_RST;
            lat_r <= LAT_RST;
            ctrl_r <= CTRL_RST;
            caled_r <= 1'b0;
        end else begin
            gate_r <= gate_nxt;
            mdp_r <= mdp_nxt;
            lat_r <= lat_nxt;
            ctrl_r <= ctrl_nxt;
            caled_r <= caled_nxt;
        end
    end

    // Lane settings straight from the registers
    // Write latency codes pass undecoded; the lane applies them
    assign gate_delay_o = gate_r;
    assign mdl_delay_o = mdp_r[MASTER_LINE_DELAY_LSB +: 8];
    assign wl_sys_lat_o = lat_r[WLSL_LSB +: 8];
    assign dg_sys_lat_o = lat_r[DGSL_LSB +: 12];
    assign drift_comp_en_o = ctrl_r[CTRL_DRIFT];

    // Checks on the bank's behaviour
    a_wait_one_cycle: assert property (@(posedge clk) disable iff (rst)
        $rose(avs_read) && !avs_write |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("waitrequest not released after one cycle");

    a_mdp_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address == OFS_MDP
        |-> avs_readdata[31:24] == 8'h00)
        else $error("master delay reserved byte not zero");

    a_lat_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address == OFS_LAT
        |-> avs_readdata[31:20] == 12'h000)
        else $error("latency reserved bits not zero");

    a_cal_half_period: assert property (@(posedge clk) disable iff (rst)
        cal_done && !wr_go |=> gate_delay_o[7:0] == {1'b0, $past(cal_period[7:1])}
        && gate_delay_o[31:24] == gate_delay_o[7:0])
        else $error("gate delay not half period after calibration");

    a_init_period: assert property (@(posedge clk) disable iff (rst)
        cal_done && !wr_go |=> mdp_r[7:0] == $past(cal_period)
        && mdp_r[15:8] == $past(cal_period))
        else $error("initial period not captured");

    a_target_track: assert property (@(posedge clk) disable iff (rst)
        period_valid && !cal_done && !wr_go && ctrl_r[1]
        |=> mdp_r[15:8] == $past(period_meas) && mdp_r[7:0] == $past(mdp_r[7:0]))
        else $error("target period not tracking");

    a_target_frozen: assert property (@(posedge clk) disable iff (rst)
        !cal_done && !wr_go && !ctrl_r[1] |=> $stable(mdp_r))
        else $error("master delay changed while updates off");

    a_drift_off_hold: assert property (@(posedge clk) disable iff (rst)
        !cal_done && !wr_go && !ctrl_r[0] |=> $stable(gate_r))
        else $error("gate delay moved with drift compensation off");

    a_wl_load: assert property (@(posedge clk) disable iff (rst)
        wl_load && !wr_go |=> wl_sys_lat_o == $past(wl_lat_in))
        else $error("write leveling latency not loaded");

    a_dg_load: assert property (@(posedge clk) disable iff (rst)
        dg_load && !wr_go |=> dg_sys_lat_o == $past(dg_lat_in))
        else $error("gate latency not loaded");

    a_lat_write: assert property (@(posedge clk) disable iff (rst)
        wr_go && avs_address == OFS_LAT && avs_byteenable == 4'hF
        |=> wl_sys_lat_o == $past(avs_writedata[19:12])
        && dg_sys_lat_o == $past(avs_writedata[11:0]))
        else $error("latency write not applied");

    // Handshake: one wait state on writes, none while the bus is quiet
    a_write_wait: assert property (@(posedge clk) disable iff (rst)
        $rose(avs_write) && !avs_read |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("write not answered after one wait state");

    a_idle_no_wait: assert property (@(posedge clk) disable iff (rst)
        !avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest high with no request");

    // Unmapped words and the control word's upper bits read zero
    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped address read not zero");

    a_ctrl_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        avs_read && !avs_waitrequest && avs_address == OFS_CTRL
        |-> avs_readdata[31:3] == 29'h0)
        else $error("control reserved bits not zero");

    // With no source active the gate delays keep their value
    a_gate_hold: assert property (@(posedge clk) disable iff (rst)
        !cal_done && !period_valid && !wr_go |=> $stable(gate_r))
        else $error("gate delay changed with no source active");

    // Full-word gate and master delay writes land as written, less reserved bits; a byte-0 control write sets the drift enable
    a_gate_write: assert property (@(posedge clk) disable iff (rst)
        wr_go && avs_address == OFS_GATE && avs_byteenable == 4'hF
        |=> gate_delay_o == $past(avs_writedata))
        else $error("gate delay write not applied");

    a_mdp_write: assert property (@(posedge clk) disable iff (rst)
        wr_go && avs_address == OFS_MDP && avs_byteenable == 4'hF
        |=> mdp_r == ($past(avs_writedata) & MDP_MASK))
        else $error("master delay write not applied");

    a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
        wr_go && avs_address == OFS_CTRL && avs_byteenable[0]
        |=> drift_comp_en_o == $past(avs_writedata[0]))
        else $error("drift compensation enable not written");

    // Each accepted measurement moves the master line delay with it
    a_master_line_delay_follow: assert property (@(posedge clk) disable iff (rst)
        period_valid && !cal_done && !wr_go && ctrl_r[CTRL_MDLUPD]
        |=> mdl_delay_o == $past(period_meas))
        else $error("master line delay not following measurement");

    // A longer period never pulls a gate delay in; the clamp keeps this at 255
    a_drift_track: assert property (@(posedge clk) disable iff (rst)
        period_valid && !cal_done && !wr_go && ctrl_r[1:0] == 2'b11 && caled_r
        && period_meas[7:1] >= mdp_r[15:9]
        |=> gate_delay_o[7:0] >= $past(gate_delay_o[7:0]))
        else $error("gate delay moved against the period change");

endmodule // bldl_regs

// ==== bench/bldl_train_model.sv ====
// Purpose: Training and calibration source facing the lane registers
// Assumes: Strobes are one clk wide, driven just after a rising edge
// Notes: Released data buses show the inverted last value, never a held one
`timescale 1ns/1ps
module bldl_train_model (
    // Clock
    input wire logic clk,
    // Strobes and data towards the register bank
    output logic cal_done,
    output logic [7:0] cal_period,
    output logic period_valid,
    output logic [7:0] period_meas,
    output logic wl_load,
    output logic [7:0] wl_lat_in,
    output logic dg_load,
    output logic [11:0] dg_lat_in
);
    // Quiet at time zero
    initial begin
        {cal_done, period_valid, wl_load, dg_load} = 4'h0;
        {cal_period, period_meas, wl_lat_in, dg_lat_in} = 36'h0;
    end

    // One strobe per call: 0 calibrate, 1 measure, 2 write leveling, 3 gate training
    task automatic strobe(input int kind, input logic [11:0] v);
        @(posedge clk);
        cal_done <= (kind == 0);
        period_valid <= (kind == 1);
        wl_load <= (kind == 2);
        dg_load <= (kind == 3);
        {cal_period, period_meas, wl_lat_in, dg_lat_in} <= {v[7:0], v[7:0], v[7:0], v};
        @(posedge clk);
        {cal_done, period_valid, wl_load, dg_load} <= 4'h0;
        {cal_period, period_meas, wl_lat_in, dg_lat_in} <= ~{v[7:0], v[7:0], v[7:0], v};
        // Let the loaded values settle before anyone looks
        @(negedge clk);
    endtask
endmodule // bldl_train_model

// ==== bench/tb_bldl_regs.sv ====
// Purpose: Self-checking bench for the lane delay and latency registers
// Assumes: Slave answers in its own time, strobe results seen next cycle
// Notes: Waitrequest and read data are taken at the same rising edge
`timescale 1ns/1ps
module tb_bldl_regs
    import bldl_pkg::*;
;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, drift_comp_en_o;
    logic cal_done, period_valid, wl_load, dg_load;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, gate_delay_o, rdata;
    logic [7:0] cal_period, period_meas, wl_lat_in, mdl_delay_o, wl_sys_lat_o;
    logic [11:0] dg_lat_in, dg_sys_lat_o;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // Register bank and its training source
    bldl_regs DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cal_done(cal_done),
        .cal_period(cal_period), .period_valid(period_valid), .period_meas(period_meas),
        .wl_load(wl_load), .wl_lat_in(wl_lat_in), .dg_load(dg_load), .dg_lat_in(dg_lat_in),
        .gate_delay_o(gate_delay_o), .mdl_delay_o(mdl_delay_o), .wl_sys_lat_o(wl_sys_lat_o),
        .dg_sys_lat_o(dg_sys_lat_o), .drift_comp_en_o(drift_comp_en_o));
    bldl_train_model u_train (.clk(clk), .cal_done(cal_done), .cal_period(cal_period),
        .period_valid(period_valid), .period_meas(period_meas), .wl_load(wl_load),
        .wl_lat_in(wl_lat_in), .dg_load(dg_load), .dg_lat_in(dg_lat_in));

    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access, held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        // Each rising edge samples waitrequest; the one that sees it low ends the access
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rdata & m, e);
    endtask

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard; the whole run needs under a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        {rst, avs_read, avs_write} = 3'b100;
        {avs_address, avs_byteenable, avs_writedata} = 40'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_GATE, 32'hFFFFFFFF, 32'h00000000);
        rdchk(OFS_MDP, 32'hFFFFFFFF, 32'h00000000);
        rdchk(OFS_LAT, 32'hFFFFFFFF, 32'h00055000);
        rdchk(4'h2, 32'hFFFFFFFF, 32'h00000000);
        rdchk(OFS_CTRL, 32'hFFFFFFFF, 32'h00000003);
        // Training loads
        u_train.strobe(2, 12'h016);
        rdchk(OFS_LAT, 32'h000FF000, 32'h00016000);
        u_train.strobe(3, 12'hABC);
        chk({20'h0, dg_sys_lat_o}, 32'h00000ABC);
        // Calibration, then drift tracking on and off
        u_train.strobe(0, 12'h040);
        rdchk(OFS_MDP, 32'h0000FFFF, 32'h00004040);
        chk(gate_delay_o, 32'h20202020);
        chk({24'h0, mdl_delay_o}, 32'h00000040);
        u_train.strobe(1, 12'h044);
        rdchk(OFS_MDP, 32'hFF00FFFF, 32'h00004440);
        chk({24'h0, mdl_delay_o}, 32'h00000044);
        chk(gate_delay_o, 32'h22222222);
        bus(1'b1, OFS_CTRL, 32'h0, 4'hF);
        chk({31'h0, drift_comp_en_o}, 32'h00000000);
        rdchk(OFS_CTRL, 32'hFFFFFFFF, 32'h00000004);
        u_train.strobe(1, 12'h050);
        rdchk(OFS_MDP, 32'h0000FFFF, 32'h00004440);
        chk(gate_delay_o, 32'h22222222);
        // Software overrides and reserved bits
        bus(1'b1, OFS_MDP, 32'hFFFFFFFF, 4'hF);
        rdchk(OFS_MDP, 32'hFFFFFFFF, 32'h00FFFFFF);
        chk({24'h0, mdl_delay_o}, 32'h000000FF);
        bus(1'b1, OFS_LAT, 32'hFFF24207, 4'hF);
        rdchk(OFS_LAT, 32'hFFFFFFFF, 32'h00024207);
        chk({24'h0, wl_sys_lat_o}, 32'h00000024);
        chk({20'h0, dg_sys_lat_o}, 32'h00000207);
        bus(1'b1, OFS_GATE, 32'h11223344, 4'hF);
        bus(1'b1, OFS_GATE, 32'hFFFFFFFF, 4'h2);
        rdchk(OFS_GATE, 32'hFFFFFFFF, 32'h1122FF44);
        chk(gate_delay_o, 32'h1122FF44);
        conclude();
    end
endmodule // tb_bldl_regs
